// ==== guard_consts.vh ====
// Behaviour
// - Guard bit 7 hides main page-05h bytes D0h..D6h until access granted.
// - Guard bit 6 hides main page-05h mask area F8h..FFh.
// - Guard bit 5 hides main 80h..C7h on pages 04h, 02h, 03h.
// - Guard bit 4 hides main page-01h bytes F8h..FFh.
// - Guard bit 3 hides main page-01h bytes 80h..F7h.
// - Guard bit 2 hides lower main memory 00h..7Ah.
// - Guard bit 1 hides auxiliary bytes 80h..FFh.
// - Guard bit 0 hides auxiliary bytes 00h..7Fh.
// - Guard bit 1 means protected, 0 unprotected; guard byte resets to 00h.
// - 32-bit password at D3h..D6h, MSB at D3h, resets to zero.
// - Summary interrupt set by any alarm flag whose enable bit is 1.
// - Alarm byte F8h bits 7..0: temp, supply, mon1, mon2, each high then low.
// - Alarm byte F9h: mon3 high bit 7, low bit 6, bits 5..0 reserved.
// - Masked warning flags are ORed into the summary interrupt too.
// - Warning byte FAh uses the same bit order as alarm byte F8h.
// - Warning byte FBh: mon3 high bit 7, low bit 6, bits 5..0 reserved.
// - Bank-select bit picks which of two mask sets feeds the summary interrupt.
// - Bank-select 0 uses page-05h masks, 1 uses page-01h masks.
// - Answer slave addresses A0h and A2h; otherwise ignore until next start.
`ifndef GUARD_CONSTS_VH
`define GUARD_CONSTS_VH

// ----------------------------------------
// Slave addresses (upper seven bits)
// ----------------------------------------
`define SLV_AUX 7'h50
`define SLV_MAIN 7'h51

// ----------------------------------------
// Pages
// ----------------------------------------
`define PAGE_USER 8'h01
`define PAGE_LUT_A 8'h02
`define PAGE_LUT_B 8'h03
`define PAGE_THRESH 8'h04
`define PAGE_PW 8'h05

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_GUARD 8'hD2
`define OFS_KEY0 8'hD3
`define OFS_KEY1 8'hD4
`define OFS_KEY2 8'hD5
`define OFS_KEY3 8'hD6
`define OFS_ALM0 8'hF8
`define OFS_ALM1 8'hF9
`define OFS_WRN0 8'hFA
`define OFS_WRN1 8'hFB

// ----------------------------------------
// Protected range bounds
// ----------------------------------------
`define PW_BLK_LO 8'hD0
`define PW_BLK_HI 8'hD6
`define MASK_BLK_LO 8'hF8
`define THR_BLK_HI 8'hC7
`define USER_BLK_HI 8'hF7
`define LOWER_BLK_HI 8'h7A

// ----------------------------------------
// Guard bit positions
// ----------------------------------------
`define G_PW_BLK 7
`define G_MASK_PW 6
`define G_THR 5
`define G_MASK_USER 4
`define G_USER 3
`define G_LOWER 2
`define G_AUX_HI 1
`define G_AUX_LO 0

// ----------------------------------------
// Reset and fixed values
// ----------------------------------------
`define GUARD_RST 8'h00
`define PW_RST 32'h00000000
`define MASK_RST 8'h00
`define MASK_HI_RST 2'h0
`define PROT_VALUE 8'hFF

`endif

// ==== pin_sync.v ====
`timescale 1ns/10ps
// Three-stage pin synchroniser; level moves once stages two and three agree
module pin_sync (
  input wire core_clk,
  input wire rstn,
  input wire pin_i,
  output wire level_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg level_q;

  // Sample chain and agreement filter
  always @(posedge core_clk) begin
    if (!rstn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level_q <= 1'b1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  assign level_o = level_q;
endmodule // pin_sync

// ==== password_read_guard_and_alert_masks.v ====
`timescale 1ns/10ps
`include "guard_consts.vh"
module password_read_guard_and_alert_masks (
  input wire core_clk,
  input wire rstn,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  input wire [7:0] table_select,
  input wire bank_select,
  input wire access_granted,
  input wire [9:0] alarm_flags,
  input wire [9:0] warning_flags,
  input wire [7:0] ext_rdata,
  output wire [7:0] ext_addr,
  output wire ext_aux,
  output wire [7:0] ext_wdata,
  output wire ext_we,
  output wire [7:0] read_guard,
  output wire [31:0] password_value,
  output wire summary_interrupt_flag
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [6:0] ST_IDLE = 7'b0000001;
  localparam [6:0] ST_ADDR = 7'b0000010;
  localparam [6:0] ST_ACK = 7'b0000100;
  localparam [6:0] ST_RX = 7'b0001000;
  localparam [6:0] ST_TX = 7'b0010000;
  localparam [6:0] ST_TACK = 7'b0100000;
  localparam [6:0] ST_WAIT = 7'b1000000;

  wire scl_s;
  wire sda_s;
  reg scl_d1_q;
  reg sda_d1_q;
  reg [6:0] state_q;
  reg [3:0] bitcnt_q;
  reg [7:0] shreg_q;
  reg [7:0] tx_q;
  reg [7:0] addr_q;
  reg aux_q;
  reg rw_q;
  reg first_q;
  reg ack_q;
  reg oe_q;
  reg [7:0] wdata_q;
  reg we_q;
  reg [7:0] guard_q;
  reg [31:0] pw_q;
  reg [7:0] alm0_q;
  reg [1:0] alm1_q;
  reg [7:0] wrn0_q;
  reg [1:0] wrn1_q;
  reg [7:0] alt_alm0_q;
  reg [1:0] alt_alm1_q;
  reg [7:0] alt_wrn0_q;
  reg [1:0] alt_wrn1_q;
  reg summary_q;
  reg [7:0] rd_byte;
  reg prot_hit;
  reg [9:0] alm_mask;
  reg [9:0] wrn_mask;

  // ----------------------------------------
  // Pin sampling and bus events
  // ----------------------------------------
  pin_sync u_scl_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin_i(scl_i),
    .level_o(scl_s)
  );

  pin_sync u_sda_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin_i(sda_i),
    .level_o(sda_s)
  );

  // Previous filtered levels for edge finding
  always @(posedge core_clk) begin
    if (!rstn) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d1_q;
  wire scl_fall = ~scl_s & scl_d1_q;
  wire start_det = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  wire stop_det = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire main_hi = ~aux_q & addr_q[7];
  wire on_pw_page = main_hi & (table_select == `PAGE_PW);
  wire on_user_page = main_hi & (table_select == `PAGE_USER);
  wire on_thr_page = main_hi & ((table_select == `PAGE_THRESH) | (table_select == `PAGE_LUT_A) |
                                (table_select == `PAGE_LUT_B));
  wire in_mask_area = (addr_q >= `MASK_BLK_LO);
  wire hit_guard = on_pw_page & (addr_q == `OFS_GUARD);
  wire hit_pw = on_pw_page & (addr_q >= `OFS_KEY0) & (addr_q <= `OFS_KEY3);
  wire hit_mask = (on_pw_page | on_user_page) & (addr_q >= `OFS_ALM0) & (addr_q <= `OFS_WRN1);
  wire hit_internal = hit_guard | hit_pw | hit_mask;

  // Protection lookup, evaluated from the live guard byte
  always @* begin
    prot_hit = 1'b0;
    if (aux_q) begin
      prot_hit = addr_q[7] ? guard_q[`G_AUX_HI] : guard_q[`G_AUX_LO];
    end else if (!addr_q[7]) begin
      prot_hit = (addr_q <= `LOWER_BLK_HI) & guard_q[`G_LOWER];
    end else if (on_pw_page) begin
      if ((addr_q >= `PW_BLK_LO) & (addr_q <= `PW_BLK_HI)) begin
        prot_hit = guard_q[`G_PW_BLK];
      end else if (in_mask_area) begin
        prot_hit = guard_q[`G_MASK_PW];
      end
    end else if (on_thr_page) begin
      prot_hit = (addr_q <= `THR_BLK_HI) & guard_q[`G_THR];
    end else if (on_user_page) begin
      prot_hit = in_mask_area ? guard_q[`G_MASK_USER] :
                 ((addr_q <= `USER_BLK_HI) & guard_q[`G_USER]);
    end
  end

  // Read value for the current address
  always @* begin
    rd_byte = ext_rdata;
    if (on_pw_page) begin
      case (addr_q)
        `OFS_GUARD: rd_byte = guard_q;
        `OFS_KEY0: rd_byte = pw_q[31:24];
        `OFS_KEY1: rd_byte = pw_q[23:16];
        `OFS_KEY2: rd_byte = pw_q[15:8];
        `OFS_KEY3: rd_byte = pw_q[7:0];
        `OFS_ALM0: rd_byte = alm0_q;
        `OFS_ALM1: rd_byte = {alm1_q, 6'h00};
        `OFS_WRN0: rd_byte = wrn0_q;
        `OFS_WRN1: rd_byte = {wrn1_q, 6'h00};
        default: rd_byte = ext_rdata;
      endcase
    end else if (on_user_page) begin
      case (addr_q)
        `OFS_ALM0: rd_byte = alt_alm0_q;
        `OFS_ALM1: rd_byte = {alt_alm1_q, 6'h00};
        `OFS_WRN0: rd_byte = alt_wrn0_q;
        `OFS_WRN1: rd_byte = {alt_wrn1_q, 6'h00};
        default: rd_byte = ext_rdata;
      endcase
    end
    if (prot_hit & ~access_granted) begin
      rd_byte = `PROT_VALUE;
    end
  end

  // ----------------------------------------
  // Serial slave state machine
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      bitcnt_q <= 4'h0;
      shreg_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= 8'h00;
      aux_q <= 1'b0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
    end else begin
      we_q <= 1'b0;
      if (start_det) begin
        state_q <= ST_ADDR;
        bitcnt_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        oe_q <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_RX: begin
            if (scl_rise && bitcnt_q != 4'h8) begin
              shreg_q <= {shreg_q[6:0], sda_s};
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (scl_fall && bitcnt_q == 4'h8) begin
              if (state_q == ST_ADDR) begin
                if (shreg_q[7:1] == `SLV_MAIN || shreg_q[7:1] == `SLV_AUX) begin
                  aux_q <= (shreg_q[7:1] != `SLV_MAIN);
                  rw_q <= shreg_q[0];
                  first_q <= ~shreg_q[0];
                  oe_q <= 1'b1;
                  state_q <= ST_ACK;
                end else begin
                  state_q <= ST_WAIT;
                end
              end else begin
                oe_q <= 1'b1;
                state_q <= ST_ACK;
                if (first_q) begin
                  addr_q <= shreg_q;
                  first_q <= 1'b0;
                end else begin
                  // Internal bytes stay here, others go out; address wraps in its row
                  we_q <= ~hit_internal;
                  wdata_q <= shreg_q;
                  addr_q <= {addr_q[7:3], addr_q[2:0] + 3'h1};
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bitcnt_q <= 4'h0;
              if (rw_q) begin
                tx_q <= rd_byte;
                oe_q <= ~rd_byte[7];
                state_q <= ST_TX;
              end else begin
                oe_q <= 1'b0;
                state_q <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bitcnt_q == 4'h7) begin
                oe_q <= 1'b0;
                addr_q <= addr_q + 8'h01;
                state_q <= ST_TACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                oe_q <= ~tx_q[6];
                bitcnt_q <= bitcnt_q + 4'h1;
              end
            end
          end
          ST_TACK: begin
            if (scl_rise) begin
              ack_q <= ~sda_s;
            end else if (scl_fall) begin
              if (ack_q) begin
                tx_q <= rd_byte;
                oe_q <= ~rd_byte[7];
                bitcnt_q <= 4'h0;
                state_q <= ST_TX;
              end else begin
                state_q <= ST_WAIT;
              end
            end
          end
          ST_IDLE, ST_WAIT: begin
            oe_q <= 1'b0;
          end
          default: begin
            state_q <= ST_IDLE;
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Register store write when a data byte completes
  wire reg_wr = (state_q == ST_RX) & scl_fall & (bitcnt_q == 4'h8) & ~first_q & ~start_det & ~stop_det;

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rstn) begin
      guard_q <= `GUARD_RST;
      pw_q <= `PW_RST;
      alm0_q <= `MASK_RST;
      alm1_q <= `MASK_HI_RST;
      wrn0_q <= `MASK_RST;
      wrn1_q <= `MASK_HI_RST;
      alt_alm0_q <= `MASK_RST;
      alt_alm1_q <= `MASK_HI_RST;
      alt_wrn0_q <= `MASK_RST;
      alt_wrn1_q <= `MASK_HI_RST;
    end else if (reg_wr) begin
      if (on_pw_page) begin
        case (addr_q)
          `OFS_GUARD: guard_q <= shreg_q;
          `OFS_KEY0: pw_q[31:24] <= shreg_q;
          `OFS_KEY1: pw_q[23:16] <= shreg_q;
          `OFS_KEY2: pw_q[15:8] <= shreg_q;
          `OFS_KEY3: pw_q[7:0] <= shreg_q;
          `OFS_ALM0: alm0_q <= shreg_q;
          `OFS_ALM1: alm1_q <= shreg_q[7:6];
          `OFS_WRN0: wrn0_q <= shreg_q;
          `OFS_WRN1: wrn1_q <= shreg_q[7:6];
          default: guard_q <= guard_q;
        endcase
      end else if (on_user_page) begin
        case (addr_q)
          `OFS_ALM0: alt_alm0_q <= shreg_q;
          `OFS_ALM1: alt_alm1_q <= shreg_q[7:6];
          `OFS_WRN0: alt_wrn0_q <= shreg_q;
          `OFS_WRN1: alt_wrn1_q <= shreg_q[7:6];
          default: guard_q <= guard_q;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Summary interrupt
  // ----------------------------------------
  // Mask set selection by the bank-select bit
  always @* begin
    if (bank_select) begin
      alm_mask = {alt_alm0_q, alt_alm1_q};
      wrn_mask = {alt_wrn0_q, alt_wrn1_q};
    end else begin
      alm_mask = {alm0_q, alm1_q};
      wrn_mask = {wrn0_q, wrn1_q};
    end
  end

  // Registered OR of masked alarm and warning flags
  always @(posedge core_clk) begin
    if (!rstn) begin
      summary_q <= 1'b0;
    end else begin
      summary_q <= (|(alarm_flags & alm_mask)) | (|(warning_flags & wrn_mask));
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign ext_addr = addr_q;
  assign ext_aux = aux_q;
  assign ext_wdata = wdata_q;
  assign ext_we = we_q;
  assign read_guard = guard_q;
  assign password_value = pw_q;
  assign summary_interrupt_flag = summary_q;
endmodule // password_read_guard_and_alert_masks

// ==== host_master.sv ====
`timescale 1ns/10ps
// I2C host on the serial pins, stepping on the core clock
module host_master (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_dn
);
  // Bus idle with both lines released
  initial begin
    scl = 1'b1;
    sda_dn = 1'b0;
  end
  task w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Bit out: data moves only while the clock is low
  task bw(input logic b);
    sda_dn <= ~b;
    w(2);
    scl <= 1'b1;
    w(5);
    scl <= 1'b0;
    w(3);
  endtask
  // Bit in: line released, sampled mid high phase
  task br(output logic b);
    sda_dn <= 1'b0;
    w(2);
    scl <= 1'b1;
    w(3);
    b = sda;
    w(2);
    scl <= 1'b0;
    w(3);
  endtask
  // Start when f is 1, stop when f is 0
  task cond(input logic f);
    sda_dn <= ~f;
    w(2);
    scl <= 1'b1;
    w(5);
    sda_dn <= f;
    w(5);
    if (f) begin
      scl <= 1'b0;
      w(3);
    end
  endtask
  task tx(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) bw(b[i]);
    br(nak);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] m, input logic [7:0] d, output logic nak);
    logic n;
    logic t;
    cond(1'b1);
    tx(a, n);
    tx(m, t);
    n = n | t;
    tx(d, t);
    nak = n | t;
    cond(1'b0);
  endtask
  // Pointer set, repeated start, one byte closed by no-ack
  task rd(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
    logic n;
    cond(1'b1);
    tx(a, n);
    tx(m, n);
    cond(1'b1);
    tx(a | 8'h01, n);
    for (int i = 7; i >= 0; i--) br(d[i]);
    bw(1'b1);
    cond(1'b0);
  endtask
endmodule // host_master

// ==== password_read_guard_and_alert_masks_properties.sv ====
`timescale 1ns/10ps
// Port checker for the guard and mask bank
module guard_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [7:0] table_select,
  input wire logic bank_select,
  input wire logic access_granted,
  input wire logic [9:0] alarm_flags,
  input wire logic [9:0] warning_flags,
  input wire logic [7:0] ext_rdata,
  input wire logic [7:0] ext_addr,
  input wire logic ext_aux,
  input wire logic [7:0] ext_wdata,
  input wire logic ext_we,
  input wire logic [7:0] read_guard,
  input wire logic [31:0] password_value,
  input wire logic summary_interrupt_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_rst_regs;
    $rose(rstn) |-> read_guard == 8'h00 && password_value == 32'h00000000;
  endproperty
  a_rst_regs: assert property (p_rst_regs) else $error("stored bytes not cleared");
  property p_rst_out;
    $rose(rstn) |-> !summary_interrupt_flag && !sda_oe && !ext_we;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  property p_idle_sum;
    alarm_flags == 10'h000 && warning_flags == 10'h000 |=> !summary_interrupt_flag;
  endproperty
  a_idle_sum: assert property (p_idle_sum) else $error("summary without flags");
  property p_sum_cause;
    $rose(summary_interrupt_flag) |-> $past(alarm_flags) != 10'h000 || $past(warning_flags) != 10'h000;
  endproperty
  a_sum_cause: assert property (p_sum_cause) else $error("summary rose with no flag");
  property p_oe_low;
    $changed(sda_oe) |-> !$past(scl_i, 3) && sda_o == 1'b0;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("data line moved outside low phase");
  property p_we_pulse;
    ext_we |=> !ext_we;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
  property p_guard_page;
    $changed(read_guard) |-> table_select == 8'h05 && !ext_aux && !ext_we;
  endproperty
  a_guard_page: assert property (p_guard_page) else $error("guard byte changed off page");
  property p_pw_page;
    $changed(password_value) |-> table_select == 8'h05 && !ext_aux && !ext_we;
  endproperty
  a_pw_page: assert property (p_pw_page) else $error("password changed off page");
  // Main scenarios reached
  c_ack: cover property ($rose(sda_oe));
  c_sum: cover property ($rose(summary_interrupt_flag));
  c_guard: cover property ($changed(read_guard));
endmodule // guard_checker

// ==== tb_password_read_guard_and_alert_masks.sv ====
`timescale 1ns/10ps
module tb_password_read_guard_and_alert_masks;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] table_select = 8'h05;
  logic bank_select = 1'b0;
  logic access_granted = 1'b0;
  logic [9:0] alarm_flags = 10'h000;
  logic [9:0] warning_flags = 10'h000;
  wire scl_i, sda_dn, sda_o, sda_oe, ext_aux, ext_we, summary_interrupt_flag;
  wire [7:0] ext_addr, ext_wdata, read_guard;
  wire [31:0] password_value;
  // Pulled-up data line and a far memory that answers its address XOR 3Ch, with bit 0 also flipped for aux
  wire sda_i = !(sda_dn || (sda_oe && !sda_o));
  wire [7:0] ext_rdata = ext_addr ^ {7'h00, ext_aux} ^ 8'h3C;
  int failures = 0;
  int compares = 0;
  logic nak;
  logic [7:0] d;
  logic [7:0] we_data = 8'h00;
  logic [15:0] m;
  logic [9:0] fl;
  logic [7:0] g_pg [8] = '{8'h05, 8'h05, 8'h04, 8'h01, 8'h01, 8'h05, 8'h05, 8'h05};
  logic [7:0] g_dv [8] = '{8'hA2, 8'hA2, 8'hA2, 8'hA2, 8'hA2, 8'hA2, 8'hA0, 8'hA0};
  logic [7:0] g_ad [8] = '{8'hD6, 8'hFF, 8'hC7, 8'hFF, 8'hF7, 8'h7A, 8'h80, 8'h7F};
  password_read_guard_and_alert_masks u_password_read_guard_and_alert_masks (.core_clk, .rstn, .scl_i,
    .sda_i, .sda_o, .sda_oe, .table_select, .bank_select, .access_granted, .alarm_flags, .warning_flags,
    .ext_rdata, .ext_addr, .ext_aux, .ext_wdata, .ext_we, .read_guard, .password_value, .summary_interrupt_flag);
  host_master u_host_master (.core_clk, .sda(sda_i), .scl(scl_i), .sda_dn);
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // Last byte sent to the far memory
  always @(posedge core_clk) begin
    if (ext_we) we_data <= ext_wdata;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task wb(input logic [7:0] a, input logic [7:0] v);
    u_host_master.wr(8'hA2, a, v, nak);
    chk(nak, 1'b0);
  endtask
  task rb(input logic [7:0] dv, input logic [7:0] a, input logic [7:0] exp);
    u_host_master.rd(dv, a, d);
    chk(d, exp);
  endtask
  function automatic logic [7:0] gexp(input int k);
    gexp = (k == 0) ? 8'h78 : g_ad[k] ^ {7'h00, g_dv[k] == 8'hA0} ^ 8'h3C;
  endfunction
  task t_reset;
    chk(read_guard, 8'h00);
    chk(password_value, 32'h00000000);
    chk(summary_interrupt_flag, 1'b0);
    rb(8'hA2, 8'hD2, 8'h00);
    rb(8'hA2, 8'hF9, 8'h00);
  endtask
  task t_pw;
    for (int i = 0; i < 4; i++) wb(8'hD3 + i[7:0], 8'h12 + 8'h22 * i[7:0]);
    chk(password_value, 32'h12345678);
    rb(8'hA2, 8'hD3, 8'h12);
  endtask
  // One guard bit at a time: its block hidden, the next block open
  task t_guard;
    for (int k = 0; k < 8; k++) begin
      table_select <= 8'h05;
      wb(8'hD2, 8'h80 >> k);
      chk(read_guard, 8'h80 >> k);
      table_select <= g_pg[k];
      rb(g_dv[k], g_ad[k], 8'hFF);
      access_granted <= 1'b1;
      rb(g_dv[k], g_ad[k], gexp(k));
      access_granted <= 1'b0;
      // Threshold guard also covers both lookup-table pages
      if (k == 2) begin
        table_select <= 8'h02;
        rb(8'hA2, 8'h80, 8'hFF);
        table_select <= 8'h03;
        rb(8'hA2, 8'hC7, 8'hFF);
      end
      table_select <= g_pg[(k + 1) % 8];
      rb(g_dv[(k + 1) % 8], g_ad[(k + 1) % 8], gexp((k + 1) % 8));
    end
    table_select <= 8'h05;
    wb(8'hD2, 8'h00);
  endtask
  // Each flag alone against its own enable bit
  task t_mask;
    table_select <= 8'h05;
    wb(8'hF9, 8'hFF);
    rb(8'hA2, 8'hF9, 8'hC0);
    for (int j = 0; j < 20; j++) begin
      m = 16'h0040 << (j % 10);
      wb(j < 10 ? 8'hF8 : 8'hFA, m[15:8]);
      wb(j < 10 ? 8'hF9 : 8'hFB, m[7:0]);
      fl = 10'h001 << (j % 10);
      {alarm_flags, warning_flags} <= j < 10 ? {fl, 10'h000} : {10'h000, fl};
      cyc(2);
      chk(summary_interrupt_flag, 1'b1);
      {alarm_flags, warning_flags} <= j < 10 ? {~fl, 10'h000} : {10'h000, ~fl};
      cyc(2);
      chk(summary_interrupt_flag, 1'b0);
    end
    bank_select <= 1'b1;
    warning_flags <= 10'h3FF;
    cyc(2);
    chk(summary_interrupt_flag, 1'b0);
    table_select <= 8'h01;
    wb(8'hF8, 8'h40);
    warning_flags <= 10'h000;
    alarm_flags <= 10'h100;
    cyc(2);
    chk(summary_interrupt_flag, 1'b1);
    bank_select <= 1'b0;
    cyc(2);
    chk(summary_interrupt_flag, 1'b0);
    alarm_flags <= 10'h000;
  endtask
  task t_addr;
    table_select <= 8'h05;
    u_host_master.wr(8'hA4, 8'hD2, 8'h55, nak);
    chk(nak, 1'b1);
    chk(read_guard, 8'h00);
    u_host_master.wr(8'hA0, 8'h10, 8'h5A, nak);
    chk(we_data, 8'h5A);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(6);
    chk(password_value, 32'h00000000);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    cyc(6);
    t_reset;
    t_pw;
    t_guard;
    t_mask;
    t_addr;
    end_sim;
  end
  // Hang guard
  initial begin
    repeat (90000) @(posedge core_clk);
    failures++;
    end_sim;
  end
endmodule // tb_password_read_guard_and_alert_masks
bind password_read_guard_and_alert_masks guard_checker u_guard_checker (.core_clk, .rstn, .scl_i, .sda_i,
  .sda_o, .sda_oe, .table_select, .bank_select, .access_granted, .alarm_flags, .warning_flags, .ext_rdata,
  .ext_addr, .ext_aux, .ext_wdata, .ext_we, .read_guard, .password_value, .summary_interrupt_flag);
